// ===== core/fir_pkg.sv
package fir_pkg;
    localparam int FULL_W       = 18;
    localparam int NARROW_W     = 9;
    localparam int DEF_TAPS     = 8;
    localparam int GRP_TAPS     = 4;
    localparam int WIDE_MULTS   = 4;
    localparam int NARROW_MULTS = 8;
    localparam int GRP_GROWTH   = 2;
    localparam int STAGE_ON     = 1;

    typedef enum logic {
        LOAD_PARALLEL = 1'h0,
        LOAD_SERIAL   = 1'h1
    } load_mode_t;
endpackage

// ===== core/fir_slice_if.sv
`timescale 1ns/10ps
interface fir_slice_if
    import fir_pkg::*;
#(
    parameter int W = FULL_W,
    parameter int N = WIDE_MULTS
);
    localparam int NG = N / GRP_TAPS;
    localparam int GW = 2 * W + GRP_GROWTH;

    logic                  serial;
    logic [N-1:0][W-1:0]   samp;
    logic [N-1:0][W-1:0]   coef;
    logic [N-1:0][W-1:0]   taps;
    logic [W-1:0]          chain_in;
    logic [W-1:0]          chain_out;
    logic [NG-1:0][GW-1:0] psum;

    modport feed (output serial, samp, coef, chain_in, input taps, chain_out, psum);
    modport core (input serial, samp, coef, chain_in, output taps, chain_out, psum);
endinterface

// ===== core/mult_add_slice.sv
`timescale 1ns/10ps
module mult_add_slice
    import fir_pkg::*;
#(
    parameter int W        = FULL_W,
    parameter int N        = WIDE_MULTS,
    parameter int IN_REG   = STAGE_ON,
    parameter int PIPE_REG = STAGE_ON,
    parameter int OUT_REG  = STAGE_ON
) (
    input wire logic  i_clk,
    input wire logic  i_rst,
    fir_slice_if.core s
);
    localparam int PW = 2 * W;
    localparam int AW = PW + 1;
    localparam int GW = PW + GRP_GROWTH;
    localparam int NG = N / GRP_TAPS;

    logic [N-1:0][W-1:0]   tap_d, tap_q, coef_q, tap_v, coef_v;
    logic [N-1:0][PW-1:0]  prod, prod_q, prod_v;
    logic [NG-1:0][GW-1:0] sum, sum_q;

    for (genvar i = 0; i < N; i++) begin : g_tap
        if (i == 0) begin : g_first
            assign tap_d[i] = s.serial ? s.chain_in : s.samp[i];
        end else begin : g_next
            assign tap_d[i] = s.serial ? tap_q[i-1] : s.samp[i];
        end
        assign prod[i] = PW'($signed(tap_v[i])) * PW'($signed(coef_v[i]));
    end

    for (genvar g = 0; g < NG; g++) begin : g_grp
        localparam int B = g * GRP_TAPS;
        logic signed [AW-1:0] pair_a, pair_b;
        assign pair_a = AW'($signed(prod_v[B])) + AW'($signed(prod_v[B+1]));
        assign pair_b = AW'($signed(prod_v[B+2])) + AW'($signed(prod_v[B+3]));
        assign sum[g] = GW'(pair_a) + GW'(pair_b);
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tap_q  <= '0;
            coef_q <= '0;
            prod_q <= '0;
            sum_q  <= '0;
        end else begin
            tap_q  <= tap_d;
            coef_q <= s.coef;
            prod_q <= prod;
            sum_q  <= sum;
        end
    end

    // serial load always runs through the tap registers
    assign tap_v       = (s.serial || IN_REG != 0) ? tap_q : s.samp;
    assign coef_v      = (IN_REG != 0) ? coef_q : s.coef;
    assign prod_v      = (PIPE_REG != 0) ? prod_q : prod;
    assign s.psum      = (OUT_REG != 0) ? sum_q : sum;
    assign s.taps      = tap_q;
    assign s.chain_out = tap_q[N-1];
endmodule

// ===== core/final_adder.sv
`timescale 1ns/10ps
module final_adder
    import fir_pkg::*;
#(
    parameter int IW = 2 * FULL_W + GRP_GROWTH,
    parameter int N  = DEF_TAPS / GRP_TAPS,
    parameter int OW = IW + 1
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    input  wire logic [N-1:0][IW-1:0] i_psum,
    output logic      [OW-1:0]        o_sum
);
    logic [OW-1:0] total;

    always_comb begin
        total = '0;
        for (int k = 0; k < N; k++) begin
            total = total + OW'($signed(i_psum[k]));
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_sum <= '0;
        end else begin
            o_sum <= total;
        end
    end
endmodule

// ===== core/cascaded_fir.sv
`timescale 1ns/10ps

module cascaded_fir
    import fir_pkg::*;
#(
    parameter int  DATA_W       = FULL_W,
    parameter int  TAPS         = DEF_TAPS,
    parameter int  USE_IN_REG   = STAGE_ON,
    parameter int  USE_PIPE_REG = STAGE_ON,
    parameter int  USE_OUT_REG  = STAGE_ON,
    localparam int MULTS        = (DATA_W <= NARROW_W) ? NARROW_MULTS : WIDE_MULTS,
    localparam int N_SLICE      = TAPS / MULTS,
    localparam int N_GRP        = TAPS / GRP_TAPS,
    localparam int GRP_W        = 2 * DATA_W + GRP_GROWTH,
    localparam int OUT_W        = GRP_W + $clog2(N_GRP)
) (
    input  wire logic                       I_MCLK,
    input  wire logic                       I_RST,
    input  wire logic                       I_SERIAL_LOAD,
    input  wire logic [DATA_W-1:0]          I_SAMPLE,
    input  wire logic [TAPS-1:0][DATA_W-1:0] I_PAR_SAMPLES,
    input  wire logic [TAPS-1:0][DATA_W-1:0] I_COEFS,
    output logic      [OUT_W-1:0]           O_RESULT,
    output logic      [DATA_W-1:0]          O_CHAIN_OUT,
    output logic                            O_VALID
);
    // registers between a tap value and the output
    localparam int POST  = USE_PIPE_REG + USE_OUT_REG + STAGE_ON;
    localparam int HIST  = POST + TAPS;
    localparam int CI    = POST + USE_IN_REG - 1;
    localparam int GPS   = MULTS / GRP_TAPS;
    localparam int EW    = OUT_W + GRP_GROWTH;
    localparam int CNT_W = $clog2(HIST + 1);

    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(HIST);
    localparam logic [CNT_W-1:0] CNT_STEP = CNT_W'(STAGE_ON);

    load_mode_t                   mode;
    load_mode_t                   mode_q;
    logic                         serial;
    logic [N_GRP-1:0][GRP_W-1:0]  grp;
    logic [CNT_W-1:0]             cnt_q;
    logic [CNT_W-1:0]             cnt_d;
    logic                         valid_q;
    logic                         mode_chg;
    logic                         cnt_sat;

    assign mode   = load_mode_t'(I_SERIAL_LOAD);
    assign serial = (mode == LOAD_SERIAL);

    for (genvar j = 0; j < N_SLICE; j++) begin : g_slice
        fir_slice_if #(
            .W (DATA_W),
            .N (MULTS)
        ) sif ();

        assign sif.serial = serial;
        assign sif.samp   = I_PAR_SAMPLES[j*MULTS +: MULTS];
        assign sif.coef   = I_COEFS[j*MULTS +: MULTS];

        if (j == 0) begin : g_head
            assign sif.chain_in = I_SAMPLE;
        end else begin : g_link
            assign sif.chain_in = g_slice[j-1].sif.chain_out;
        end

        // 9-bit build: one slice hands over two 4-tap halves
        assign grp[j*GPS +: GPS] = sif.psum;

        mult_add_slice #(
            .W        (DATA_W),
            .N        (MULTS),
            .IN_REG   (USE_IN_REG),
            .PIPE_REG (USE_PIPE_REG),
            .OUT_REG  (USE_OUT_REG)
        ) u_slice (
            .i_clk (I_MCLK),
            .i_rst (I_RST),
            .s     (sif.core)
        );
    end

    final_adder #(
        .IW (GRP_W),
        .N  (N_GRP),
        .OW (OUT_W)
    ) u_add (
        .i_clk  (I_MCLK),
        .i_rst  (I_RST),
        .i_psum (grp),
        .o_sum  (O_RESULT)
    );

    assign O_CHAIN_OUT = g_slice[N_SLICE-1].sif.chain_out;

    // window fill count since reset or a change of load mode
    assign mode_chg = (mode != mode_q);
    assign cnt_sat  = (cnt_q == CNT_FULL);
    assign cnt_d    = mode_chg ? '0 : (cnt_sat ? cnt_q : cnt_q + CNT_STEP);

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            mode_q  <= LOAD_PARALLEL;
            cnt_q   <= '0;
            valid_q <= 1'h0;
        end else begin
            mode_q  <= mode;
            cnt_q   <= cnt_d;
            valid_q <= (cnt_d == CNT_FULL);
        end
    end

    assign O_VALID = valid_q;

    // reference model, read only by the checks below
    logic [DATA_W-1:0]           x_hist_q [HIST];
    logic [TAPS-1:0][DATA_W-1:0] p_hist_q [POST+1];
    logic [TAPS-1:0][DATA_W-1:0] c_hist_q [POST+1];
    logic [DATA_W-1:0]           ref_smp;
    logic [DATA_W-1:0]           ref_coef;
    logic signed [EW-1:0]        ref_sum;
    logic signed [EW-1:0]        grp_sum;
    logic signed [EW-1:0]        res_ext;

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            x_hist_q <= '{default: '0};
            p_hist_q <= '{default: '0};
            c_hist_q <= '{default: '0};
        end else begin
            x_hist_q[0] <= I_SAMPLE;
            p_hist_q[0] <= I_PAR_SAMPLES;
            c_hist_q[0] <= I_COEFS;
            for (int k = 1; k < HIST; k++) begin
                x_hist_q[k] <= x_hist_q[k-1];
            end
            for (int k = 1; k <= POST; k++) begin
                p_hist_q[k] <= p_hist_q[k-1];
                c_hist_q[k] <= c_hist_q[k-1];
            end
        end
    end

    always_comb begin
        ref_sum  = '0;
        ref_smp  = '0;
        ref_coef = '0;
        for (int i = 0; i < TAPS; i++) begin
            ref_smp  = (mode_q == LOAD_SERIAL) ? x_hist_q[POST+i] : p_hist_q[CI][i];
            ref_coef = c_hist_q[CI][i];
            ref_sum  = ref_sum + EW'($signed(ref_smp)) * EW'($signed(ref_coef));
        end
    end

    always_comb begin
        grp_sum = '0;
        for (int k = 0; k < N_GRP; k++) begin
            grp_sum = grp_sum + EW'($signed(grp[k]));
        end
    end

    assign res_ext = EW'($signed(O_RESULT));

    default clocking cb @(posedge I_MCLK);
    endclocking

    default disable iff (I_RST);

    property p_conv;
        O_VALID |-> res_ext == ref_sum;
    endproperty

    a_conv: assert property (p_conv)
        else $error("filter output differs from the tap sum");

    property p_reset_zero;
        $past(I_RST) |-> O_RESULT == '0 && !O_VALID;
    endproperty

    a_reset_zero: assert property (p_reset_zero)
        else $error("output not cleared by reset");

    property p_valid_drop;
        $changed(I_SERIAL_LOAD) |=> !O_VALID ##1 !O_VALID;
    endproperty

    a_valid_drop: assert property (p_valid_drop)
        else $error("valid kept across a load mode change");

    property p_valid_time;
        $rose(O_VALID) |-> $past(I_RST, HIST+1) ||
            ($past(I_SERIAL_LOAD, HIST+1) !=
                ($past(I_RST, HIST+2) ? LOAD_PARALLEL : $past(I_SERIAL_LOAD, HIST+2)));
    endproperty

    a_valid_time: assert property (p_valid_time)
        else $error("valid rose after the wrong fill time");

    property p_feed;
        $past(serial) && !$past(I_RST) |->
            g_slice[0].sif.taps[0] == $past(I_SAMPLE);
    endproperty

    a_feed: assert property (p_feed)
        else $error("first tap did not take the serial sample");

    property p_shift;
        $past(serial) && !$past(I_RST) |->
            g_slice[0].sif.taps[1] == $past(g_slice[0].sif.taps[0]);
    endproperty

    a_shift: assert property (p_shift)
        else $error("tap line did not shift by one sample");

    if (N_SLICE > 1) begin : g_chk_cross
        property p_cross;
            $past(serial) && !$past(I_RST) |->
                g_slice[1].sif.taps[0] == $past(g_slice[0].sif.chain_out);
        endproperty

        a_cross: assert property (p_cross)
            else $error("chain broken between slices");
    end

    property p_par;
        !$past(serial) && !$past(I_RST) |->
            g_slice[0].sif.taps == $past(I_PAR_SAMPLES[MULTS-1:0]);
    endproperty

    a_par: assert property (p_par)
        else $error("parallel load did not reach the taps");

    property p_adder;
        !$past(I_RST) |-> res_ext == $past(grp_sum);
    endproperty

    a_adder: assert property (p_adder)
        else $error("outside adder sum wrong or overflowed");

    property p_chain_tail;
        O_VALID && mode_q == LOAD_SERIAL |-> O_CHAIN_OUT == x_hist_q[TAPS-1];
    endproperty

    a_chain_tail: assert property (p_chain_tail)
        else $error("chain output is not the oldest tap sample");

    property p_valid_hold;
        O_VALID && !mode_chg |=> O_VALID;
    endproperty

    a_valid_hold: assert property (p_valid_hold)
        else $error("valid dropped without reset or mode change");

    property p_par_tail;
        !$past(serial) && !$past(I_RST) |->
            g_slice[N_SLICE-1].sif.taps == $past(I_PAR_SAMPLES[TAPS-1 -: MULTS]);
    endproperty

    a_par_tail: assert property (p_par_tail)
        else $error("parallel load did not reach the last slice");

    property p_tail_shift;
        $past(serial) && !$past(I_RST) |->
            g_slice[N_SLICE-1].sif.taps[MULTS-1] ==
                $past(g_slice[N_SLICE-1].sif.taps[MULTS-2]);
    endproperty

    a_tail_shift: assert property (p_tail_shift)
        else $error("last slice tap line did not shift");

    property p_coef_in;
        !$past(I_RST) |-> g_slice[0].u_slice.coef_q == $past(I_COEFS[MULTS-1:0]);
    endproperty

    a_coef_in: assert property (p_coef_in)
        else $error("coefficients not captured by the input stage");

    // group sums stand one adder stage ahead of the output
    if (CI > 0) begin : g_chk_grp
        logic [DATA_W-1:0]    grp_smp;
        logic signed [EW-1:0] ref_grp;

        always_comb begin
            ref_grp = '0;
            grp_smp = '0;
            for (int i = 0; i < GRP_TAPS; i++) begin
                grp_smp = (mode_q == LOAD_SERIAL) ? x_hist_q[POST-1+i] : p_hist_q[CI-1][i];
                ref_grp = ref_grp + EW'($signed(grp_smp)) * EW'($signed(c_hist_q[CI-1][i]));
            end
        end

        property p_grp;
            O_VALID |-> EW'($signed(grp[0])) == ref_grp;
        endproperty

        a_grp: assert property (p_grp)
            else $error("first slice group sum wrong");
    end

    property p_cov_serial;
        serial && O_VALID ##1 O_RESULT != '0;
    endproperty

    c_serial: cover property (p_cov_serial);

    property p_cov_par;
        !serial && O_VALID ##1 O_RESULT != '0;
    endproperty

    c_par: cover property (p_cov_par);

    property p_cov_neg;
        O_VALID && O_RESULT[OUT_W-1];
    endproperty

    c_neg: cover property (p_cov_neg);

    property p_cov_switch;
        O_VALID ##1 $changed(I_SERIAL_LOAD) ##1 !O_VALID;
    endproperty

    c_switch: cover property (p_cov_switch);
endmodule

// ===== tb/fir_source.sv
`timescale 1ns/10ps
module fir_source
    import fir_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_run,
    input  wire logic              i_mode,
    input  wire logic [1:0]        i_kind,
    output logic                   o_serial,
    output logic [FULL_W-1:0]      o_sample,
    output logic [7:0][FULL_W-1:0] o_par,
    output logic [7:0][FULL_W-1:0] o_coefs
);
    int k = 0;

    function automatic logic [FULL_W-1:0] pat(input logic [1:0] kd, input int n);
        case (kd)
            2'h0:    pat = (n == 0) ? 18'h0_0001 : 18'h0_0000;
            2'h1:    pat = FULL_W'(n * 3 - 20);
            2'h2:    pat = n[3] ? 18'h1_FFFF : 18'h2_0000;
            default: pat = FULL_W'(n * 977 - 4000);
        endcase
    endfunction

    function automatic logic [FULL_W-1:0] cof(input logic [1:0] kd, input int n, input int i);
        case (kd)
            2'h0:    cof = FULL_W'(i + 1);
            2'h2:    cof = 18'h2_0000;
            2'h3:    cof = FULL_W'(n * 13 + i * 7 - 30);
            default: cof = FULL_W'(i * 5 - 17);
        endcase
    endfunction

    initial begin
        o_serial = 1'b0;
        o_sample = '0;
        o_par    = '0;
        o_coefs  = '0;
    end

    // idle stream shows changing garbage, never the last value
    always @(negedge i_clk) begin
        o_serial <= i_mode;
        if (i_run) begin
            k        <= k + 1;
            o_sample <= pat(i_kind, k);
            o_par[0] <= pat(i_kind, k);
            for (int i = 1; i < 8; i++) begin
                o_par[i] <= o_par[i-1];
            end
            for (int i = 0; i < 8; i++) begin
                o_coefs[i] <= cof(i_kind, k, i);
            end
        end else begin
            k        <= 0;
            o_sample <= ~o_sample;
            o_par    <= ~o_par;
            o_coefs  <= ~o_coefs;
        end
    end
endmodule

// ===== tb/test_cascaded_fir.sv
`timescale 1ns/10ps
module test_cascaded_fir;
    import fir_pkg::*;
    localparam int OW = 2 * FULL_W + GRP_GROWTH + 1;

    logic                   clk, rst, run, mode, serial, valid;
    logic [1:0]             kind;
    logic [FULL_W-1:0]      samp, chain;
    logic [7:0][FULL_W-1:0] par, cf;
    logic [OW-1:0]          res;
    int                     error_cnt = 0;
    int                     cmp_count = 0;
    int                     edge_n    = 0;
    logic [FULL_W-1:0]      lg_s [0:1023];
    logic [7:0][FULL_W-1:0] lg_p [0:1023];
    logic [7:0][FULL_W-1:0] lg_c [0:1023];
    logic                   lg_m [0:1023];
    logic                   lg_r [0:1023];

    fir_source src (.i_clk(clk), .i_run(run), .i_mode(mode), .i_kind(kind),
        .o_serial(serial), .o_sample(samp), .o_par(par), .o_coefs(cf));

    cascaded_fir uut (.I_MCLK(clk), .I_RST(rst), .I_SERIAL_LOAD(serial), .I_SAMPLE(samp),
        .I_PAR_SAMPLES(par), .I_COEFS(cf), .O_RESULT(res), .O_CHAIN_OUT(chain),
        .O_VALID(valid));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // record what each edge takes in
    always @(posedge clk) begin
        edge_n = edge_n + 1;
        lg_s[edge_n] = samp;
        lg_p[edge_n] = par;
        lg_c[edge_n] = cf;
        lg_m[edge_n] = serial;
        lg_r[edge_n] = rst;
    end

    task automatic judge(input logic bad, input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (bad) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_res(input logic [OW-1:0] got, input logic [OW-1:0] exp);
        judge(got !== exp, 64'(got), 64'(exp));
    endtask

    task automatic chk_dat(input logic [FULL_W-1:0] got, input logic [FULL_W-1:0] exp);
        judge(got !== exp, 64'(got), 64'(exp));
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        judge(got !== exp, 64'(got), 64'(exp));
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one cycle: judge outputs against the logged inputs
    task automatic step();
        logic          ok, vok, m;
        longint        acc;
        int            e;
        @(negedge clk);
        e = edge_n;
        m = lg_m[e];
        ok = 1'b1;
        vok = 1'b1;
        for (int j = 0; j < 15; j++) begin
            if (e - j < 1 || lg_r[e-j] || lg_m[e-j] !== m) begin
                vok = 1'b0;
                if (j < 12) ok = 1'b0;
            end
        end
        if (ok) begin
            acc = 0;
            for (int i = 0; i < 8; i++) begin
                acc += longint'($signed(m ? lg_s[e-3-i] : lg_p[e-3][i]))
                     * longint'($signed(lg_c[e-3][i]));
            end
            chk_res(res, OW'(acc));
            if (m) chk_dat(chain, lg_s[e-7]);
        end
        if (vok) chk_bit(valid, 1'b1);
    endtask

    task automatic switch_to(input logic m, input logic [1:0] kd, input logic gap);
        run  <= ~gap;
        mode <= m;
        kind <= kd;
        step();
        run <= 1'b1;
        step();
        chk_bit(valid, 1'b0);
    endtask

    task automatic t_reset();
        repeat (10) @(negedge clk);
        chk_res(res, '0);
        chk_dat(chain, '0);
        chk_bit(valid, 1'b0);
        rst <= 1'b0;
        @(negedge clk);
        chk_bit(valid, 1'b0);
        $display("test reset done");
    endtask

    task automatic t_impulse_serial();
        switch_to(1'b1, 2'h0, 1'b1);
        repeat (24) step();
        $display("test serial impulse done");
    endtask

    task automatic t_ramp_parallel();
        switch_to(1'b0, 2'h1, 1'b0);
        repeat (24) step();
        $display("test parallel ramp done");
    endtask

    task automatic t_extreme_serial();
        switch_to(1'b1, 2'h2, 1'b0);
        repeat (40) step();
        $display("test full scale done");
    endtask

    task automatic t_adaptive_parallel();
        switch_to(1'b0, 2'h3, 1'b0);
        repeat (24) step();
        $display("test adaptive coefficients done");
    endtask

    task automatic t_midreset();
        switch_to(1'b1, 2'h3, 1'b0);
        repeat (14) step();
        rst <= 1'b1;
        repeat (3) step();
        chk_res(res, '0);
        chk_dat(chain, '0);
        chk_bit(valid, 1'b0);
        rst <= 1'b0;
        repeat (24) step();
        $display("test reset in run done");
    endtask

    initial begin
        rst  = 1'b1;
        run  = 1'b0;
        mode = 1'b0;
        kind = 2'h0;
        t_reset();
        t_impulse_serial();
        t_ramp_parallel();
        t_extreme_serial();
        t_adaptive_parallel();
        t_midreset();
        wrap_up();
    end

    initial begin
        #200000;
        error_cnt++;
        wrap_up();
    end
endmodule
